/* File: hdl/ref_map.svh */
// Constants of the restricted earth-fault core
`ifndef REF_MAP_SVH
`define REF_MAP_SVH
`define REF_PH_W 16
`define REF_CW 27
`define REF_DW 29
`define REF_SQ_W 58
`define REF_RT_W 29
`define REF_TH_W 40
`define REF_CNT_W 5
`define REF_ROOT_LAST 5'h1c
`define REF_PCT 7'h64
`define REF_BOOST_SHIFT 2
`define REF_PICKUP_MIN 6'h0a
`define REF_PICKUP_MAX 6'h32
`define REF_PICKUP_DEF 6'h1e
`define REF_SLOPE_MIN 7'h32
`define REF_SLOPE_MAX 7'h64
`define REF_SLOPE_DEF 7'h46
`define REF_BRK_MIN 8'h64
`define REF_BRK_MAX 8'hc8
`define REF_BRK_DEF 8'h7d
`define REF_PRI_MIN 9'h014
`define REF_PRI_MAX 9'h1f4
`define REF_PRI_DEF 9'h064
`define REF_NEUT_MIN 10'h064
`define REF_NEUT_MAX 10'h3e8
`define REF_NEUT_DEF 10'h1f4
`endif

/* File: hdl/ref_pkg.sv */
// Types of the restricted earth-fault core
`include "ref_map.svh"
package ref_pkg;
	typedef struct packed {
		logic signed [`REF_PH_W-1:0] re;
		logic signed [`REF_PH_W-1:0] im;
	} phasor_t;
	typedef struct packed {
		phasor_t phase1_phasor;
		phasor_t phase2_phasor;
		phasor_t phase3_phasor;
		phasor_t neutral_phasor;
	} phasor_set_t;
	typedef struct packed {
		logic operation_setting;
		logic direction_check_enable;
		logic [5:0] base_pickup_setting;
		logic [6:0] slope_setting;
		logic [7:0] break_point_setting;
		logic [8:0] primary_comp_setting;
		logic [9:0] neutral_comp_setting;
	} settings_t;
	localparam settings_t SETTINGS_DEF = '{
		operation_setting: 1'b1,
		direction_check_enable: 1'b1,
		base_pickup_setting: `REF_PICKUP_DEF,
		slope_setting: `REF_SLOPE_DEF,
		break_point_setting: `REF_BRK_DEF,
		primary_comp_setting: `REF_PRI_DEF,
		neutral_comp_setting: `REF_NEUT_DEF
	};
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_COMP = 3'b001,
		S_SQUARE = 3'b010,
		S_ROOT = 3'b011,
		S_DECIDE = 3'b100
	} state_t;
endpackage

/* File: hdl/restricted_earth_fault_logic.sv */
// Zero-sequence differential (restricted earth-fault) protection core
`timescale 1ns/10ps
`default_nettype none
`include "ref_map.svh"
module restricted_earth_fault_logic (
	input wire logic clock_i, // 250 MHz
	input wire logic srst_i, // Sync reset
	input wire logic phasor_valid_i, // New set offered
	input wire ref_pkg::phasor_set_t phasors_i, // Fundamentals
	output logic ready_o, // Core idle, set taken
	input wire logic settings_wr_i, // Settings write strobe
	input wire ref_pkg::settings_t settings_i, // Settings to write
	output ref_pkg::settings_t settings_o, // Settings in force
	input wire logic external_block_in_i, // External block
	input wire logic sensitivity_boost_in_i, // Quarter base pickup
	output logic direction_start_flag_o, // Direction start
	output logic internal_trip_flag_o, // Above characteristic
	output logic general_trip_out_o, // General trip
	output logic result_valid_o, // Outputs just updated
	output logic [`REF_RT_W-1:0] diff_current_value_o, // 0.01 %
	output logic [`REF_RT_W-1:0] restraint_current_value_o // 0.01 %
);
	import ref_pkg::*;

	localparam int AW = `REF_SQ_W + 2;

	// ==========================================================
	// Functions
	function automatic logic signed [`REF_CW-1:0] comp(
		input logic signed [`REF_PH_W-1:0] x,
		input logic [9:0] k);
		comp = x * $signed({1'b0, k});
	endfunction

	function automatic logic [`REF_SQ_W-1:0] mag_sq(
		input logic signed [`REF_DW-1:0] re,
		input logic signed [`REF_DW-1:0] im);
		logic signed [`REF_SQ_W-1:0] a;
		logic signed [`REF_SQ_W-1:0] b;
		a = re * re;
		b = im * im;
		mag_sq = $unsigned(a) + $unsigned(b);
	endfunction

	// One digit of a restoring square root: returns {rem, root}
	function automatic logic [2*`REF_RT_W+1:0] sqrt_step(
		input logic [`REF_RT_W+1:0] rem,
		input logic [`REF_RT_W-1:0] root,
		input logic [1:0] two);
		logic [`REF_RT_W+1:0] r2;
		logic [`REF_RT_W+1:0] t;
		r2 = {rem[`REF_RT_W-1:0], two};
		t = {root, 2'b01};
		if (r2 >= t) begin
			sqrt_step = {r2 - t, root[`REF_RT_W-2:0], 1'b1};
		end else begin
			sqrt_step = {r2, root[`REF_RT_W-2:0], 1'b0};
		end
	endfunction

	// ==========================================================
	// Settings
	settings_t cfg, next_cfg;
	logic cfg_ok;

	// Out-of-range writes are dropped whole, so no half-set mix
	assign cfg_ok =
		settings_i.base_pickup_setting >= `REF_PICKUP_MIN &&
		settings_i.base_pickup_setting <= `REF_PICKUP_MAX &&
		settings_i.slope_setting >= `REF_SLOPE_MIN &&
		settings_i.slope_setting <= `REF_SLOPE_MAX &&
		settings_i.break_point_setting >= `REF_BRK_MIN &&
		settings_i.break_point_setting <= `REF_BRK_MAX &&
		settings_i.primary_comp_setting >= `REF_PRI_MIN &&
		settings_i.primary_comp_setting <= `REF_PRI_MAX &&
		settings_i.neutral_comp_setting >= `REF_NEUT_MIN &&
		settings_i.neutral_comp_setting <= `REF_NEUT_MAX;

	always_comb begin
		next_cfg = cfg;
		if (settings_wr_i && cfg_ok) begin
			next_cfg = settings_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			cfg <= SETTINGS_DEF;
		end else begin
			cfg <= next_cfg;
		end
	end

	assign settings_o = cfg;

	// ==========================================================
	// Datapath
	state_t state, next_state;
	logic [`REF_CNT_W-1:0] cnt, next_cnt;
	phasor_set_t raw, next_raw;
	logic dir_q, next_dir;
	logic signed [`REF_DW-1:0] dre, dim, next_dre, next_dim;
	logic [`REF_SQ_W-1:0] rad_d, rad_r, next_rad_d, next_rad_r;
	logic [`REF_RT_W+1:0] rem_d, rem_r, next_rem_d, next_rem_r;
	logic [`REF_RT_W-1:0] root_d, root_r, next_root_d, next_root_r;
	logic next_dir_o, next_int, next_gen, next_valid;
	logic [`REF_RT_W-1:0] next_dval, next_rval;

	logic signed [`REF_CW-1:0] cre [0:3];
	logic signed [`REF_CW-1:0] cim [0:3];
	logic signed [`REF_DW-1:0] z_re, z_im;
	logic signed [`REF_SQ_W-1:0] dot;
	logic [`REF_SQ_W-1:0] sq_max;
	logic [`REF_RT_W-1:0] brk;
	logic [`REF_TH_W-1:0] base, lhs, rhs;
	logic blocked;
	logic [9:0] pri_k;
	// Compensated phasors stay valid while the raw set is held
	assign cre[0] = comp(raw.phase1_phasor.re, pri_k);
	assign cim[0] = comp(raw.phase1_phasor.im, pri_k);
	assign cre[1] = comp(raw.phase2_phasor.re, pri_k);
	assign cim[1] = comp(raw.phase2_phasor.im, pri_k);
	assign cre[2] = comp(raw.phase3_phasor.re, pri_k);
	assign cim[2] = comp(raw.phase3_phasor.im, pri_k);
	assign cre[3] = comp(raw.neutral_phasor.re, cfg.neutral_comp_setting);
	assign cim[3] = comp(raw.neutral_phasor.im, cfg.neutral_comp_setting);
	assign pri_k = 10'(cfg.primary_comp_setting);
	assign z_re = `REF_DW'(cre[0]) + `REF_DW'(cre[1]) + `REF_DW'(cre[2]);
	assign z_im = `REF_DW'(cim[0]) + `REF_DW'(cim[1]) + `REF_DW'(cim[2]);
	// Negative real part of 3I0 * conj(IN): angle beyond +-90 deg
	assign dot = z_re * `REF_DW'(cre[3]) + z_im * `REF_DW'(cim[3]);
	always_comb begin
		sq_max = '0;
		for (int i = 0; i < 4; i++) begin
			if (mag_sq(`REF_DW'(cre[i]), `REF_DW'(cim[i])) > sq_max) begin
				sq_max = mag_sq(`REF_DW'(cre[i]), `REF_DW'(cim[i]));
			end
		end
	end

	// Both sides scaled by 100 so no divider is needed
	assign brk = `REF_RT_W'(cfg.break_point_setting) * `REF_RT_W'(`REF_PCT);
	assign base = `REF_TH_W'(cfg.base_pickup_setting) *
		`REF_TH_W'(`REF_PCT) * `REF_TH_W'(`REF_PCT);
	assign lhs = `REF_TH_W'(root_d) * `REF_TH_W'(`REF_PCT);
	assign rhs = (sensitivity_boost_in_i ?
		(base >> `REF_BOOST_SHIFT) : base) +
		((root_r > brk) ? `REF_TH_W'(cfg.slope_setting) *
		`REF_TH_W'(root_r - brk) : '0);
	assign blocked = external_block_in_i |
		(cfg.direction_check_enable & dir_q);
	assign ready_o = (state == S_IDLE);
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_raw = raw;
		next_dir = dir_q;
		next_dre = dre;
		next_dim = dim;
		next_rad_d = rad_d;
		next_rad_r = rad_r;
		next_rem_d = rem_d;
		next_rem_r = rem_r;
		next_root_d = root_d;
		next_root_r = root_r;
		next_dir_o = direction_start_flag_o;
		next_int = internal_trip_flag_o;
		next_gen = general_trip_out_o;
		next_dval = diff_current_value_o;
		next_rval = restraint_current_value_o;
		next_valid = 1'b0;
		unique case (state)
			S_IDLE: begin
				if (phasor_valid_i) begin
					next_raw = phasors_i;
					next_state = S_COMP;
				end
			end
			S_COMP: begin
				next_dir = (dot < 0);
				next_dre = z_re + `REF_DW'(cre[3]);
				next_dim = z_im + `REF_DW'(cim[3]);
				next_state = S_SQUARE;
			end
			S_SQUARE: begin
				next_rad_d = mag_sq(dre, dim);
				next_rad_r = sq_max;
				next_rem_d = '0;
				next_rem_r = '0;
				next_root_d = '0;
				next_root_r = '0;
				next_cnt = '0;
				next_state = S_ROOT;
			end
			S_ROOT: begin
				{next_rem_d, next_root_d} = sqrt_step(rem_d, root_d,
					rad_d[(`REF_SQ_W-1)-2*cnt -: 2]);
				{next_rem_r, next_root_r} = sqrt_step(rem_r, root_r,
					rad_r[(`REF_SQ_W-1)-2*cnt -: 2]);
				next_cnt = cnt + 1'b1;
				if (cnt == `REF_ROOT_LAST) begin
					next_state = S_DECIDE;
				end
			end
			S_DECIDE: begin
				next_dir_o = dir_q;
				next_int = (lhs > rhs);
				next_gen = next_int & ~blocked &
					cfg.operation_setting;
				next_dval = root_d;
				next_rval = root_r;
				next_valid = 1'b1;
				next_state = S_IDLE;
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state <= S_IDLE;
			cnt <= '0;
			raw <= '0;
			dir_q <= 1'b0;
			dre <= '0;
			dim <= '0;
			rad_d <= '0;
			rad_r <= '0;
			rem_d <= '0;
			rem_r <= '0;
			root_d <= '0;
			root_r <= '0;
			direction_start_flag_o <= 1'b0;
			internal_trip_flag_o <= 1'b0;
			general_trip_out_o <= 1'b0;
			diff_current_value_o <= '0;
			restraint_current_value_o <= '0;
			result_valid_o <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			raw <= next_raw;
			dir_q <= next_dir;
			dre <= next_dre;
			dim <= next_dim;
			rad_d <= next_rad_d;
			rad_r <= next_rad_r;
			rem_d <= next_rem_d;
			rem_r <= next_rem_r;
			root_d <= next_root_d;
			root_r <= next_root_r;
			direction_start_flag_o <= next_dir_o;
			internal_trip_flag_o <= next_int;
			general_trip_out_o <= next_gen;
			diff_current_value_o <= next_dval;
			restraint_current_value_o <= next_rval;
			result_valid_o <= next_valid;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	AST_LATENCY: assert property (
		phasor_valid_i && ready_o |-> ##33 result_valid_o)
		else $error("result not delivered 33 cycles after accept");
	AST_BUSY: assert property (
		phasor_valid_i && ready_o |=> !ready_o [*8])
		else $error("core ready again too early");
	AST_HOLD: assert property (
		!result_valid_o |-> $stable(general_trip_out_o))
		else $error("trip changed without a new result");
	AST_DIR_SIGN: assert property (
		state == S_SQUARE |-> dir_q == (dot < 0))
		else $error("direction flag disagrees with phasor angle");
	AST_ROOTS: assert property (
		state == S_DECIDE |->
		AW'(root_r) * AW'(root_r) <= AW'(rad_r) &&
		(AW'(root_r) + 1) * (AW'(root_r) + 1) > AW'(rad_r) &&
		AW'(root_d) * AW'(root_d) <= AW'(rad_d) &&
		(AW'(root_d) + 1) * (AW'(root_d) + 1) > AW'(rad_d))
		else $error("magnitude root is wrong");
	AST_ZERO_DIFF: assert property (
		result_valid_o && diff_current_value_o == '0 |->
		!internal_trip_flag_o)
		else $error("trip with zero differential current");
	AST_GEN_TRIP: assert property (
		result_valid_o && general_trip_out_o |->
		internal_trip_flag_o && $past(cfg.operation_setting) &&
		!$past(external_block_in_i) &&
		!($past(cfg.direction_check_enable) && direction_start_flag_o))
		else $error("general trip without all conditions");
	AST_OFF: assert property (
		result_valid_o && !$past(cfg.operation_setting) |->
		!general_trip_out_o)
		else $error("trip while operation is Off");
	AST_RANGE: assert property (
		cfg.base_pickup_setting inside {[`REF_PICKUP_MIN:`REF_PICKUP_MAX]} &&
		cfg.slope_setting inside {[`REF_SLOPE_MIN:`REF_SLOPE_MAX]} &&
		cfg.break_point_setting inside {[`REF_BRK_MIN:`REF_BRK_MAX]} &&
		cfg.primary_comp_setting inside {[`REF_PRI_MIN:`REF_PRI_MAX]} &&
		cfg.neutral_comp_setting inside {[`REF_NEUT_MIN:`REF_NEUT_MAX]})
		else $error("setting out of range");
	AST_DEFAULTS: assert property (
		$past(srst_i) |-> cfg == SETTINGS_DEF)
		else $error("settings not at defaults after reset");

	COV_TRIP: cover property (result_valid_o && general_trip_out_o);
	COV_DIR_BLOCK: cover property (result_valid_o &&
		internal_trip_flag_o && direction_start_flag_o &&
		!general_trip_out_o);
	COV_BOOST: cover property (state == S_DECIDE &&
		sensitivity_boost_in_i && next_int);
	COV_REFUSED: cover property (settings_wr_i && !cfg_ok);
endmodule
`default_nettype wire

/* File: sim/phasor_source.sv */
// Model of the upstream phasor preparation stage
`timescale 1ns/10ps
`default_nettype none
module phasor_source (
	input wire logic clock_i, // Core clock
	input wire logic ready_i, // Core idle
	output logic valid_o, // Set offered
	output ref_pkg::phasor_set_t set_o // Offered set
);
	import ref_pkg::*;
	initial begin
		valid_o = 1'b0;
		set_o = '0;
	end
	// ==========================================
	// Offer one whole set, hold it until taken
	task automatic offer(input phasor_set_t s, input int gap);
		repeat (gap + 1) @(negedge clock_i);
		valid_o = 1'b1;
		set_o = s;
		while (ready_i !== 1'b1) @(negedge clock_i);
		@(negedge clock_i);
		valid_o = 1'b0;
		// Stale data is inverted so a late sample cannot pass by luck
		set_o = ~s;
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the restricted earth-fault core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import ref_pkg::*;
	typedef struct packed {
		logic dir;
		logic itrip;
		logic gtrip;
		logic [28:0] diff;
		logic [28:0] bias;
	} exp_t;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic wr = 1'b0;
	logic blk = 1'b0;
	logic bst = 1'b0;
	logic valid, ready, dir, itr, gtr, rv;
	logic [28:0] dval, bval;
	phasor_set_t pset;
	settings_t sset = '0;
	settings_t sout, cur;
	int mismatches = 0;
	int checks = 0;
	exp_t q[$];
	initial forever #2 clock_i = ~clock_i;
	phasor_source src (.clock_i(clock_i), .ready_i(ready), .valid_o(valid),
		.set_o(pset));
	restricted_earth_fault_logic dut (.clock_i(clock_i), .srst_i(srst_i),
		.phasor_valid_i(valid), .phasors_i(pset), .ready_o(ready),
		.settings_wr_i(wr), .settings_i(sset), .settings_o(sout),
		.external_block_in_i(blk), .sensitivity_boost_in_i(bst),
		.direction_start_flag_o(dir), .internal_trip_flag_o(itr),
		.general_trip_out_o(gtr), .result_valid_o(rv),
		.diff_current_value_o(dval), .restraint_current_value_o(bval));
	// ==========================================
	// Reference arithmetic
	function automatic longint isqrt(input longint v);
		longint r = 0;
		for (int b = 29; b >= 0; b--)
			if ((r + (64'sh1 << b)) ** 2 <= v) r += 64'sh1 << b;
		return r;
	endfunction
	function automatic exp_t model(input phasor_set_t p, input settings_t s,
		input logic b, input logic u);
		phasor_t ph[4];
		longint re[4], im[4];
		longint zr, zi, m, bias, thr, brk;
		exp_t e;
		ph = '{p.phase1_phasor, p.phase2_phasor, p.phase3_phasor,
			p.neutral_phasor};
		bias = 0;
		for (int k = 0; k < 4; k++) begin
			m = (k < 3) ? s.primary_comp_setting : s.neutral_comp_setting;
			re[k] = longint'(ph[k].re) * m;
			im[k] = longint'(ph[k].im) * m;
			m = isqrt(re[k] ** 2 + im[k] ** 2);
			if (m > bias) bias = m;
		end
		zr = re[0] + re[1] + re[2];
		zi = im[0] + im[1] + im[2];
		e.dir = (zr * re[3] + zi * im[3]) < 0;
		e.diff = 29'(isqrt((zr + re[3]) ** 2 + (zi + im[3]) ** 2));
		e.bias = 29'(bias);
		thr = (longint'(s.base_pickup_setting) * 64'sh2710) >>> (u ? 2 : 0);
		brk = longint'(s.break_point_setting) * 64'sh64;
		if (bias > brk) thr += longint'(s.slope_setting) * (bias - brk);
		e.itrip = longint'(e.diff) * 64'sh64 > thr;
		e.gtrip = e.itrip && !b && !(s.direction_check_enable && e.dir)
			&& s.operation_setting;
		return e;
	endfunction
	function automatic int pick(input int lo, input int hi, input bit brink);
		if (!brink) return $urandom_range(hi, lo);
		case ($urandom_range(3))
			0: return lo - 1;
			1: return lo;
			2: return hi;
			default: return hi + 1;
		endcase
	endfunction
	function automatic settings_t rnd_set(input bit brink);
		settings_t s;
		s.operation_setting = 1'($urandom);
		s.direction_check_enable = 1'($urandom);
		s.base_pickup_setting = 6'(pick(10, 50, brink));
		s.slope_setting = 7'(pick(50, 100, brink));
		s.break_point_setting = 8'(pick(100, 200, brink));
		s.primary_comp_setting = 9'(pick(20, 500, brink));
		s.neutral_comp_setting = 10'(pick(100, 1000, brink));
		return s;
	endfunction
	function automatic bit in_rng(input settings_t s);
		return s.base_pickup_setting inside {[10:50]}
			&& s.slope_setting inside {[50:100]}
			&& s.break_point_setting inside {[100:200]}
			&& s.primary_comp_setting inside {[20:500]}
			&& s.neutral_comp_setting inside {[100:1000]};
	endfunction
	function automatic phasor_t rnd_ph(input int sh);
		phasor_t r;
		r.re = $signed(16'($urandom)) >>> sh;
		r.im = $signed(16'($urandom)) >>> sh;
		return r;
	endfunction
	// ==========================================
	// Checking and closing
	task automatic cmp(input logic [63:0] e, input logic [63:0] g);
		checks++;
		if (e !== g) begin
			mismatches++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wr_set(input settings_t s);
		@(negedge clock_i);
		wr = 1'b1;
		sset = s;
		if (in_rng(s)) cur = s;
		@(negedge clock_i);
		wr = 1'b0;
		cmp(64'(cur), 64'(sout));
	endtask
	always @(negedge clock_i) begin
		if (rv === 1'b1) begin
			if (q.size() == 0)
				cmp(64'h0, 64'h1);
			else
				cmp(64'(q.pop_front()), 64'({dir, itr, gtr, dval, bval}));
		end
	end
	initial begin
		#100000;
		mismatches++;
		give_verdict();
	end
	// ==========================================
	// Tests
	initial begin
		phasor_set_t p;
		void'($urandom(32'h00431d69));
		repeat (12) @(negedge clock_i);
		srst_i = 1'b0;
		cur = '{1'b1, 1'b1, 6'h1e, 7'h46, 8'h7d, 9'h064, 10'h1f4};
		cmp(64'(cur), 64'(sout));
		cmp(64'h10, 64'({ready, rv, gtr, itr, dir}));
		$display("test reset done");
		repeat (40) wr_set(rnd_set(1'b1));
		$display("test settings done");
		for (int i = 0; i < 240; i++) begin
			if (i % 4 == 0) begin
				while (ready !== 1'b1) @(negedge clock_i);
				blk = 1'($urandom);
				bst = 1'($urandom);
				wr_set(rnd_set(1'b0));
			end
			p.phase1_phasor = rnd_ph($urandom_range(15, 2));
			p.phase2_phasor = rnd_ph($urandom_range(15, 2));
			p.phase3_phasor = rnd_ph($urandom_range(15, 2));
			p.neutral_phasor = rnd_ph($urandom_range(15, 2));
			// Balanced phases: heavy restraint, little zero sequence
			if ($urandom_range(1)) begin
				p.phase3_phasor.re = -(p.phase1_phasor.re + p.phase2_phasor.re);
				p.phase3_phasor.im = -(p.phase1_phasor.im + p.phase2_phasor.im);
			end
			q.push_back(model(p, cur, blk, bst));
			src.offer(p, $urandom_range(2));
		end
		for (int k = 0; k < 100 && q.size() > 0; k++) @(negedge clock_i);
		cmp(64'h0, 64'(q.size()));
		$display("test phasors done");
		give_verdict();
	end
endmodule
`default_nettype wire
